// ### src/bfrs_top.sv
// Purpose: brake sequence fault detection and automatic retry supervisor
// Assumes: speed and sequence inputs come from logic on clk; brake feedback is a pin
// Notes: retry reset never touches protection accumulators; only sys_rst clears them
module bfrs_top #(
	parameter int unsigned TICK_CYCLES = bfrs_pkg::TICK_CYCLES
) (
	// clock and reset
	input  logic                        clk,
	input  logic                        sys_rst,
	input  logic                        clk_en,
	// configuration
	input  logic [3:0]                  brake_sequence_mode,
	input  logic [2:0]                  retry_select,
	input  logic [6:0]                  retry_count_limit,
	input  logic [6:0]                  retry_wait_time,
	input  logic                        decel_check_enable,
	input  logic [13:0]                 overspeed_threshold,
	// drive status
	input  logic                        vector_control,
	input  logic signed [15:0]          detected_speed,
	input  logic signed [15:0]          output_speed,
	input  logic                        decel_running,
	input  logic                        decel_abnormal,
	input  logic                        stall_prev_active,
	input  logic                        motor_standstill,
	input  logic                        run_fwd,
	input  logic                        run_rev,
	input  logic                        brake_open_cmd,
	input  logic                        ext_fault,
	input  logic [3:0]                  ext_fault_class,
	input  logic                        alarm_reset,
	// brake link
	input  logic                        brake_open_done_fb,
	output logic                        brake_open_request,
	// retry counter access
	input  logic                        counter_wr,
	input  logic [bfrs_pkg::CNT_W-1:0]  counter_wr_data,
	output logic [bfrs_pkg::CNT_W-1:0]  retry_success_counter,
	// status out
	output logic                        output_enable,
	output logic                        alarm_active,
	output logic                        alarm_out,
	output logic                        retry_reset,
	output logic                        protect_clear,
	output logic                        retry_excess_fault,
	output logic [3:0]                  fault_code
);
	import bfrs_pkg::*;

	function automatic logic [3:0] lim_decode(input logic [6:0] lim);
		if (lim >= 7'd1 && lim <= LIM_MAX) begin
			lim_decode = lim[3:0];
		end else if (lim > LIM_PULSE_BASE && lim <= LIM_PULSE_BASE + LIM_MAX) begin
			lim_decode = 4'(lim - LIM_PULSE_BASE);
		end else begin
			lim_decode = 4'h0;
		end
	endfunction

	function automatic logic retry_allowed(input logic [2:0] sel, input logic [3:0] fc);
		logic oc;
		logic ov;
		oc = (fc == BFRS_FC_OC_ACCEL) || (fc == BFRS_FC_OC_CONST) || (fc == BFRS_FC_OC_DECEL);
		ov = (fc == BFRS_FC_OV);
		case (sel)
			3'h0: retry_allowed = !(fc inside {BFRS_FC_OPEN_TO, BFRS_FC_FB_LOST, BFRS_FC_NO_RETRY,
				BFRS_FC_RETRY_EXC, BFRS_FC_NONE});
			3'h1: retry_allowed = oc;
			3'h2: retry_allowed = ov;
			3'h3: retry_allowed = oc || ov;
			3'h4: retry_allowed = oc || ov || (fc inside {BFRS_FC_GENERAL, BFRS_FC_OVERSPEED, BFRS_FC_DECEL,
				BFRS_FC_REQ_TO, BFRS_FC_OPEN_TO, BFRS_FC_FB_LOST});
			3'h5: retry_allowed = (fc == BFRS_FC_OC_DECEL);
			default: retry_allowed = 1'b0;
		endcase
	endfunction

	// feedback pin synchroniser
	logic fb_s1_q, fb_s2_q, fb_prev_q, fb_seen_q, fb_seen_d;
	logic cmd_prev_q, run_prev_q, bof_q, bof_d;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fb_s1_q <= 1'b0;
			fb_s2_q <= 1'b0;
		end else if (clk_en) begin
			fb_s1_q <= brake_open_done_fb;
			fb_s2_q <= fb_s1_q;
		end
	end

	bfrs_state_t      state_q, state_d;
	logic [3:0]       code_q, code_d, tries_q, tries_d;
	logic             excess_q, excess_d, win_q, win_d, rec_q, rec_d;
	logic             rrst_q, rrst_d, aout_q, aout_d, oen_q, oen_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;

	logic tick, run_cmd, seq_on, fb_mode, in_run;
	logic cmd_rise, cmd_fall, run_rise;
	logic to_req, to_open, to_close, wait_done, win_done;
	logic signed [16:0] speed_diff;
	logic [7:1]         flt;
	logic [3:0]         new_code, lim_n;
	logic               new_fault, succ, clr;

	assign run_cmd    = run_fwd || run_rev;
	assign seq_on     = (brake_sequence_mode == MODE_WITH_FB) || (brake_sequence_mode == MODE_NO_FB);
	assign fb_mode    = (brake_sequence_mode == MODE_WITH_FB);
	assign in_run     = (state_q == BFRS_ST_RUN);
	assign cmd_rise   = brake_open_cmd && !cmd_prev_q;
	assign cmd_fall   = !brake_open_cmd && cmd_prev_q;
	assign run_rise   = run_cmd && !run_prev_q;
	assign speed_diff = 17'(detected_speed) - 17'(output_speed);
	assign lim_n      = lim_decode(retry_count_limit);

	bfrs_tick #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_tick (
		.clk     (clk),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.tick    (tick)
	);

	bfrs_timer u_req_to (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.tick     (tick),
		.start    (run_rise || rrst_q), // re-armed on restart, else a stale expiry refaults at once
		.run      (run_cmd && !brake_open_cmd),
		.load_val (BRAKE_TO_TICKS),
		.expired  (to_req)
	);

	bfrs_timer u_open_to (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.tick     (tick),
		.start    (cmd_rise),
		.run      (brake_open_cmd && !fb_s2_q),
		.load_val (BRAKE_TO_TICKS),
		.expired  (to_open)
	);

	bfrs_timer u_close_to (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.tick     (tick),
		.start    (cmd_fall),
		.run      (!brake_open_cmd && fb_s2_q),
		.load_val (BRAKE_TO_TICKS),
		.expired  (to_close)
	);

	bfrs_timer u_wait (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.tick     (tick),
		.start    (in_run && state_d == BFRS_ST_WAIT),
		.run      (state_q == BFRS_ST_WAIT),
		.load_val (TMR_W'(retry_wait_time)),
		.expired  (wait_done)
	);

	bfrs_timer u_win (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.tick     (tick),
		.start    (rrst_d),
		.run      (win_q && in_run),
		.load_val (TMR_W'(SUCC_FACTOR * retry_wait_time)),
		.expired  (win_done)
	);

	// fault detection, brake faults only while running the brake sequence, external faults whenever in run
	always_comb begin
		flt    = '0;
		flt[1] = vector_control && (overspeed_threshold != OVS_DISABLE)
			&& (speed_diff > $signed({3'b000, overspeed_threshold}));
		flt[2] = decel_check_enable && decel_running && decel_abnormal && !stall_prev_active;
		flt[3] = cmd_rise && motor_standstill;
		flt[4] = to_req;
		flt[5] = fb_mode && to_open;
		flt[6] = fb_mode && bof_q && fb_seen_q && fb_prev_q && !fb_s2_q;
		flt[7] = fb_mode && to_close;
		if (!(seq_on && in_run)) begin
			flt = '0;
		end
		new_code = BFRS_FC_NONE;
		for (int i = 7; i >= 1; i--) begin
			if (flt[i]) begin
				new_code = 4'(i);
			end
		end
		if (new_code == BFRS_FC_NONE && ext_fault) begin
			new_code = ext_fault_class;
		end
		new_fault = in_run && (|flt || ext_fault);
	end

	// retry sequencer
	always_comb begin
		state_d  = state_q;
		code_d   = code_q;
		tries_d  = tries_q;
		excess_d = excess_q;
		win_d    = win_q;
		rec_d    = rec_q;
		rrst_d   = 1'b0;
		aout_d   = aout_q;
		oen_d    = oen_q;
		succ     = 1'b0;
		case (state_q)
			BFRS_ST_RUN: begin
				if (new_fault) begin
					oen_d = 1'b0;
					if (!rec_q) begin
						code_d = new_code;
						rec_d  = 1'b1;
					end
					if (lim_n != 4'h0 && retry_allowed(retry_select, new_code)) begin
						if (tries_q < lim_n) begin
							tries_d = tries_q + 4'h1;
							state_d = BFRS_ST_WAIT;
							aout_d  = (retry_count_limit > LIM_PULSE_BASE);
						end else begin
							excess_d = 1'b1;
							code_d   = BFRS_FC_RETRY_EXC;
							state_d  = BFRS_ST_ALARM;
							aout_d   = 1'b1;
						end
					end else begin
						state_d = BFRS_ST_ALARM;
						aout_d  = 1'b1;
					end
				end else if (win_done) begin
					succ    = 1'b1;
					win_d   = 1'b0;
					tries_d = 4'h0;
					rec_d   = 1'b0;
				end
			end
			BFRS_ST_WAIT: begin
				if (wait_done) begin
					state_d = BFRS_ST_RUN;
					rrst_d  = 1'b1;
					win_d   = 1'b1;
					aout_d  = 1'b0;
					oen_d   = 1'b1;
				end
			end
			BFRS_ST_ALARM: begin
				if (alarm_reset) begin
					state_d  = BFRS_ST_RUN;
					excess_d = 1'b0;
					tries_d  = 4'h0;
					win_d    = 1'b0;
					rec_d    = 1'b0;
					code_d   = BFRS_FC_NONE;
					aout_d   = 1'b0;
					oen_d    = 1'b1;
				end
			end
			default: begin
				state_d = BFRS_ST_ALARM;
				oen_d   = 1'b0;
			end
		endcase
		clr = counter_wr && (counter_wr_data == '0);
		cnt_d = cnt_q;
		if (clr) begin
			cnt_d = CNT_RESET;
		end
		if (succ && cnt_q != '1) begin
			cnt_d = (clr ? CNT_RESET : cnt_q) + CNT_W'(1);
		end
		fb_seen_d = fb_seen_q;
		if (!bof_q) begin
			fb_seen_d = 1'b0;
		end else if (fb_s2_q) begin
			fb_seen_d = 1'b1;
		end
		bof_d = brake_open_cmd && state_d == BFRS_ST_RUN && !new_fault;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q    <= BFRS_ST_RUN;
			code_q     <= BFRS_FC_NONE;
			tries_q    <= 4'h0;
			excess_q   <= 1'b0;
			win_q      <= 1'b0;
			rec_q      <= 1'b0;
			rrst_q     <= 1'b0;
			aout_q     <= 1'b0;
			oen_q      <= 1'b1;
			cnt_q      <= CNT_RESET;
			fb_prev_q  <= 1'b0;
			fb_seen_q  <= 1'b0;
			cmd_prev_q <= 1'b0;
			run_prev_q <= 1'b0;
			bof_q      <= 1'b0;
		end else if (clk_en) begin
			state_q    <= state_d;
			code_q     <= code_d;
			tries_q    <= tries_d;
			excess_q   <= excess_d;
			win_q      <= win_d;
			rec_q      <= rec_d;
			rrst_q     <= rrst_d;
			aout_q     <= aout_d;
			oen_q      <= oen_d;
			cnt_q      <= cnt_d;
			fb_prev_q  <= fb_s2_q;
			fb_seen_q  <= fb_seen_d;
			cmd_prev_q <= brake_open_cmd;
			run_prev_q <= run_cmd;
			bof_q      <= bof_d;
		end
	end

	// protection accumulators clear on power-on reset only, never on retry
	logic pclr_q;
	always_ff @(posedge clk) begin
		pclr_q <= sys_rst;
	end

	assign brake_open_request    = bof_q;
	assign output_enable         = oen_q;
	assign alarm_active          = (state_q != BFRS_ST_RUN);
	assign alarm_out             = aout_q;
	assign retry_reset           = rrst_q;
	assign protect_clear         = pclr_q;
	assign retry_excess_fault    = excess_q;
	assign fault_code            = code_q;
	assign retry_success_counter = cnt_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_alarm_blocks_req: assert property (alarm_active |-> !brake_open_request) else $error("request on in alarm");
	a_fault_cuts_out: assert property (clk_en && new_fault |=> !output_enable && !brake_open_request)
		else $error("output not cut on fault");
	a_ovs_disabled: assert property (overspeed_threshold == OVS_DISABLE |-> !flt[1])
		else $error("overspeed fault while disabled");
	a_decel_gate: assert property ((!decel_check_enable || stall_prev_active) |-> !flt[2])
		else $error("decel fault while masked");
	a_mode8_no_fb: assert property (!fb_mode |-> flt[7:5] == 3'b000)
		else $error("feedback fault without feedback mode");
	a_zero_no_retry: assert property (clk_en && new_fault && retry_count_limit == 7'd0
		|=> state_q == BFRS_ST_ALARM) else $error("retry with count zero");
	a_excess_alarm: assert property ($rose(retry_excess_fault)
		|-> alarm_active && fault_code == BFRS_FC_RETRY_EXC) else $error("excess without alarm");
	a_wait_no_out: assert property (state_q == BFRS_ST_WAIT |-> !output_enable && !retry_reset)
		else $error("output on while waiting");
	a_cnt_clear: assert property (clk_en && clr && !succ |=> retry_success_counter == '0)
		else $error("counter not cleared");
	a_cnt_inc: assert property (clk_en && succ && !clr && cnt_q != '1 |=> cnt_q == $past(cnt_q) + CNT_W'(1))
		else $error("counter not incremented");
	a_first_rec: assert property (clk_en && rec_q && new_fault && lim_n > tries_q
		&& retry_allowed(retry_select, new_code) |=> $stable(fault_code))
		else $error("fault record overwritten");

	c_retry_ok: cover property (retry_reset ##[1:1000] succ);
	c_excess: cover property ($rose(retry_excess_fault));
	c_open_to: cover property (flt[5]);
	c_fb_lost: cover property (flt[6]);
endmodule

// ### src/bfrs_pkg.sv
// Purpose: shared constants and types of the brake fault and retry supervisor
// Assumes: 100 MHz system clock, 100 ms supervision tick
// Notes: speeds are signed r/min; wait time counts in 100 ms steps (0..100 = 0..10 s)
//
// Notes on behaviour
// - any brake fault: alarm, output off, request off
// - fault 1: detected minus output speed exceeds threshold
// - fault 2: abnormal decel, not during stall prevention
// - fault 3: open request rises at standstill
// - fault 4: no open request 2 s after run
// - fault 5: no feedback 2 s after request
// - fault 6: feedback lost while request asserted
// - fault 7: feedback still on 2 s after release
// - retriable major fault: auto reset and restart
// - retry selection 0..5 picks retried fault classes
// - brake faults retried per selection 0/4 table
// - count 0 off, 1..10 silent, 101..110 alarm pulsed
// - retries exhausted: report retry excess fault
// - wait programmed delay before retry restart
// - success counter readable, writing zero clears it
// - success after four wait times fault free
// - keep first fault record within success window
// - retry reset keeps protection accumulations
// - feedback faults only in sequence mode 7
// - threshold 9999 disables overspeed fault
// - decel check zero disables fault 2
package bfrs_pkg;
	localparam int unsigned CLK_HZ         = 100_000_000;
	localparam int unsigned TICK_MS        = 100;
	localparam int unsigned TICK_CYCLES    = (CLK_HZ / 1000) * TICK_MS;
	localparam int unsigned BRAKE_TO_MS    = 2000;
	localparam int unsigned TMR_W          = 9;
	localparam logic [8:0]  BRAKE_TO_TICKS = 9'(BRAKE_TO_MS / TICK_MS);
	localparam int unsigned SUCC_FACTOR    = 4;
	localparam int unsigned CNT_W          = 16;

	localparam logic [3:0]  MODE_WITH_FB   = 4'h7;
	localparam logic [3:0]  MODE_NO_FB     = 4'h8;
	localparam logic [13:0] OVS_DISABLE    = 14'd9999;
	localparam logic [6:0]  LIM_PULSE_BASE = 7'd100;
	localparam logic [6:0]  LIM_MAX        = 7'd10;
	localparam logic [6:0]  WAIT_MAX       = 7'd100;
	localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;

	typedef enum logic [3:0] {
		BFRS_FC_NONE      = 4'h0,
		BFRS_FC_OVERSPEED = 4'h1,
		BFRS_FC_DECEL     = 4'h2,
		BFRS_FC_GRAVITY   = 4'h3,
		BFRS_FC_REQ_TO    = 4'h4,
		BFRS_FC_OPEN_TO   = 4'h5,
		BFRS_FC_FB_LOST   = 4'h6,
		BFRS_FC_CLOSE_TO  = 4'h7,
		BFRS_FC_OC_ACCEL  = 4'h8,
		BFRS_FC_OC_CONST  = 4'h9,
		BFRS_FC_OC_DECEL  = 4'ha,
		BFRS_FC_OV        = 4'hb,
		BFRS_FC_GENERAL   = 4'hc,
		BFRS_FC_SEL0_ONLY = 4'hd,
		BFRS_FC_NO_RETRY  = 4'he,
		BFRS_FC_RETRY_EXC = 4'hf
	} bfrs_fault_t;

	typedef enum logic [2:0] {
		BFRS_ST_RUN   = 3'b001,
		BFRS_ST_WAIT  = 3'b010,
		BFRS_ST_ALARM = 3'b100
	} bfrs_state_t;
endpackage

// ### src/bfrs_tick.sv
// Purpose: one-cycle tick every TICK_CYCLES enabled clocks
// Assumes: clk_en freezes the divider
// Notes: all supervision times are multiples of this tick
module bfrs_tick #(
	parameter int unsigned TICK_CYCLES = bfrs_pkg::TICK_CYCLES
) (
	// clock and reset
	input  logic clk,
	input  logic sys_rst,
	input  logic clk_en,
	// tick out
	output logic tick
);
	import bfrs_pkg::*;
	logic [31:0] div_q, div_d;

	always_comb begin
		div_d = div_q;
		if (clk_en) begin
			div_d = (div_q == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 : div_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			div_q <= 32'h0000_0000;
		end else begin
			div_q <= div_d;
		end
	end

	assign tick = clk_en && (div_q == 32'(TICK_CYCLES - 1));
endmodule

// ### src/bfrs_timer.sv
// Purpose: tick-based down counter, reloaded by a start pulse
// Assumes: start and run come from logic on clk
// Notes: resolution is one tick, so a timeout may run up to one tick short
module bfrs_timer (
	// clock and reset
	input  logic                      clk,
	input  logic                      sys_rst,
	input  logic                      clk_en,
	input  logic                      tick,
	// control
	input  logic                      start,
	input  logic                      run,
	input  logic [bfrs_pkg::TMR_W-1:0] load_val,
	// status
	output logic                      expired
);
	import bfrs_pkg::*;
	logic [TMR_W-1:0] cnt_q, cnt_d;
	logic             act_q, act_d;

	always_comb begin
		cnt_d = cnt_q;
		act_d = act_q;
		if (clk_en) begin
			if (start) begin
				cnt_d = load_val;
				act_d = 1'b1;
			end else if (!run) begin
				act_d = 1'b0;
			end else if (act_q && tick && cnt_q != '0) begin
				cnt_d = cnt_q - TMR_W'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_q <= '0;
			act_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			act_q <= act_d;
		end
	end

	assign expired = act_q && run && (cnt_q == '0);
endmodule

// ### verif/bfrs_brake_model.sv
// Purpose: behavioural mechanical brake with open-done contact
// Assumes: request sampled on clk; knobs driven by the bench only
// Notes: contact is always driven, it has no high-impedance state
module bfrs_brake_model (
	// clock
	input  wire logic       clk,
	// fault knobs
	input  wire logic [7:0] delay,
	input  wire logic       no_open,
	input  wire logic       no_close,
	input  wire logic       drop,
	// brake link
	input  wire logic       brake_open_request,
	output logic            brake_open_done_fb
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_q;
	logic       open_q;
	initial begin
		cnt_q = 8'h00;
		open_q = 1'b0;
	end
	// mechanical delay before the contact follows the request
	always @(posedge clk) begin
		if (brake_open_request !== open_q) begin
			cnt_q <= cnt_q + 8'h01;
			if (cnt_q >= delay && (brake_open_request ? !no_open : !no_close)) begin
				open_q <= brake_open_request;
				cnt_q <= 8'h00;
			end
		end else begin
			cnt_q <= 8'h00;
		end
	end
	assign brake_open_done_fb = open_q & !drop;
endmodule

// ### verif/bfrs_tb_top.sv
// Purpose: self-checking bench of the brake fault and retry supervisor
// Assumes: tick shortened to 10 cycles, so 2 s is 200 cycles
// Notes: trips are queued by the driver and checked by the monitor
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; $display("Error at %0t: mismatch got %0h exp %0h", $time, g, e); end end
module bfrs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import bfrs_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] mode, cls, fc, e;
	logic [2:0] sel;
	logic [6:0] lim, wt;
	logic [13:0] thr;
	logic signed [15:0] det, outs;
	logic [15:0] cwd, cnt;
	logic [7:0] bdly;
	logic dce, vc, decr, deca, stall, stand, rfwd, rrev, cmd, ext, arst, fb, cwr, no_open, no_close, drop;
	logic req, oe, aa, ao, rr, pc, exf, oe_prev, pend, ce;
	logic [3:0] exp_q[$];
	int n_errors = 0;
	int total_checks = 0;
	int n, s, c, r_thr, r_out;

	always #5 clk = ~clk;

	bfrs_top #(.TICK_CYCLES(10)) i_bfrs_top (.clk(clk), .sys_rst(sys_rst), .clk_en(ce),
		.brake_sequence_mode(mode), .retry_select(sel), .retry_count_limit(lim), .retry_wait_time(wt),
		.decel_check_enable(dce), .overspeed_threshold(thr), .vector_control(vc), .detected_speed(det),
		.output_speed(outs), .decel_running(decr), .decel_abnormal(deca), .stall_prev_active(stall),
		.motor_standstill(stand), .run_fwd(rfwd), .run_rev(rrev), .brake_open_cmd(cmd), .ext_fault(ext),
		.ext_fault_class(cls), .alarm_reset(arst), .brake_open_done_fb(fb), .brake_open_request(req),
		.counter_wr(cwr), .counter_wr_data(cwd), .retry_success_counter(cnt), .output_enable(oe),
		.alarm_active(aa), .alarm_out(ao), .retry_reset(rr), .protect_clear(pc), .retry_excess_fault(exf),
		.fault_code(fc));

	bfrs_brake_model i_bfrs_brake_model (.clk(clk), .delay(bdly), .no_open(no_open), .no_close(no_close),
		.drop(drop), .brake_open_request(req), .brake_open_done_fb(fb));

	// compares two edges after output enable falls, when the record has landed
	always @(posedge clk) begin
		if (pend === 1'b1) begin
			if (exp_q.size() == 0) begin
				n_errors++;
				$display("Error at %0t: unexpected trip", $time);
			end else begin
				e = exp_q.pop_front();
				`CHK(fc, e)
			end
		end
		pend <= !sys_rst && oe_prev === 1'b1 && oe === 1'b0;
		oe_prev <= oe;
	end

	function automatic bit retried(int s, int c);
		case (c)
			1, 2, 4: return s == 0 || s == 4 || 0;
			3, 7, 13: return s == 0;
			5, 6: return s == 4;
			8, 9: return s inside {0, 1, 3, 4};
			10: return s inside {0, 1, 3, 4, 5};
			11: return s inside {0, 2, 3, 4};
			12: return s == 0 || s == 4;
			default: return 0;
		endcase
	endfunction

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask

	task automatic idle;
		mode <= 4'h7; sel <= 3'h0; lim <= 7'h00; wt <= 7'h01; dce <= 1'b0; thr <= 14'h270f;
		vc <= 1'b0; det <= 16'sh0000; outs <= 16'sh0000; decr <= 1'b0; deca <= 1'b0; stall <= 1'b0;
		stand <= 1'b0; rfwd <= 1'b0; rrev <= 1'b0; cmd <= 1'b0; ext <= 1'b0; cls <= 4'h0; arst <= 1'b0;
		cwr <= 1'b0; cwd <= 16'h0000; bdly <= 8'h05; no_open <= 1'b0; no_close <= 1'b0; drop <= 1'b0; ce <= 1'b1;
	endtask

	task automatic rst;
		@(posedge clk);
		sys_rst <= 1'b1;
		cyc(2);
		`CHK(pc, 1'b1)
		sys_rst <= 1'b0;
		idle;
		cyc(2);
	endtask

	task automatic wait_oe(input logic v, input int k);
		int i;
		for (i = 0; i < k && oe !== v; i++) cyc(1);
		if (oe !== v) begin
			n_errors++;
			$display("Error at %0t: output enable wait ran out", $time);
		end
	endtask

	task automatic trip(input logic [3:0] code, input int k);
		exp_q.push_back(code);
		wait_oe(1'b0, k);
		cyc(2);
		@(negedge clk);
		`CHK(req, 1'b0)
		`CHK(aa, 1'b1)
	endtask

	task automatic pulse(input logic [3:0] k);
		cls <= k;
		ext <= 1'b1;
		cyc(1);
		ext <= 1'b0;
	endtask

	task automatic wr_cnt(input logic [15:0] d);
		@(posedge clk);
		cwd <= d;
		cwr <= 1'b1;
		cyc(1);
		cwr <= 1'b0;
		cyc(1);
		@(negedge clk);
	endtask

	task automatic tally_and_finish;
		if (exp_q.size() != 0) begin
			n_errors++;
			$display("Error at %0t: expected trips not seen", $time);
		end
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		cyc(60000);
		n_errors++;
		$display("Error at %0t: watchdog expired", $time);
		tally_and_finish;
	end

	initial begin
		void'($urandom(32'h6b78322b));
		idle;
		cyc(17);
		rst; rrev <= 1'b1; trip(4'h4, 260);
		rst; no_open <= 1'b1; rfwd <= 1'b1; cmd <= 1'b1; trip(4'h5, 260);
		rst; rfwd <= 1'b1; cmd <= 1'b1; cyc(40);
		`CHK(req, 1'b1)
		drop <= 1'b1; trip(4'h6, 20);
		rst; rfwd <= 1'b1; cmd <= 1'b1; cyc(40); no_close <= 1'b1; rfwd <= 1'b0; cmd <= 1'b0;
		trip(4'h7, 260);
		rst; stand <= 1'b1; cyc(3); cmd <= 1'b1; trip(4'h3, 20);
		// frozen clock enable must hold the request timer where it stands
		rst; rrev <= 1'b1; cyc(150); ce <= 1'b0; cyc(200);
		`CHK(oe, 1'b1)
		ce <= 1'b1; trip(4'h4, 120);
		$display("test brake timing done");
		r_thr = $urandom_range(900);
		r_out = $urandom_range(1000);
		rst; vc <= 1'b1; thr <= 14'(r_thr); outs <= 16'(r_out); det <= 16'(r_out + r_thr);
		cyc(20); det <= 16'(r_out + r_thr + 1); trip(4'h1, 20);
		rst; vc <= 1'b1; det <= 16'sd12000; cyc(20);
		thr <= 14'h0064; det <= -16'sh01f4; cyc(20);
		rst; decr <= 1'b1; deca <= 1'b1; stall <= 1'b1; dce <= 1'b1; cyc(20);
		stall <= 1'b0; dce <= 1'b0; cyc(20); dce <= 1'b1; trip(4'h2, 20);
		rst; mode <= 4'h8; rfwd <= 1'b1; cmd <= 1'b1; no_open <= 1'b1; cyc(260);
		mode <= 4'h0; cmd <= 1'b0; cyc(260);
		@(negedge clk);
		`CHK(oe, 1'b1)
		$display("test speed and mode done");
		for (s = 0; s < 6; s++) begin
			for (c = 1; c < 15; c++) begin
				rst; sel <= 3'(s); lim <= 7'h01; wt <= 7'h0a; cyc(1); pulse(4'(c));
				trip(4'(c), 5);
				`CHK(ao, !retried(s, c))
			end
		end
		$display("test retry table done");
		rst; lim <= 7'd101; wt <= 7'h03; cyc(1); pulse(4'h8); trip(4'h8, 5);
		`CHK(ao, 1'b1)
		n = 0;
		while (rr !== 1'b1 && n < 60) begin
			cyc(1);
			n++;
		end
		`CHK(n >= 15 && n <= 30, 1'b1)
		@(negedge clk);
		`CHK(pc, 1'b0)
		wait_oe(1'b1, 5);
		cyc(100); @(negedge clk);
		`CHK(cnt, 16'h0000)
		cyc(40); @(negedge clk);
		`CHK(cnt, 16'h0001)
		wr_cnt(16'h0005);
		`CHK(cnt, 16'h0001)
		wr_cnt(16'h0000);
		`CHK(cnt, 16'h0000)
		$display("test retry success done");
		rst; lim <= 7'h02; cyc(1); pulse(4'h8); trip(4'h8, 5);
		wait_oe(1'b1, 40); pulse(4'hb); trip(4'h8, 5);
		wait_oe(1'b1, 40); pulse(4'h9); trip(4'hf, 5);
		`CHK(exf, 1'b1)
		cyc(1); arst <= 1'b1; cyc(1); arst <= 1'b0; cyc(3); @(negedge clk);
		`CHK(exf, 1'b0)
		$display("test retry excess done");
		cyc(5);
		tally_and_finish;
	end
endmodule
